/* File: hdl/hbs_host_cycles.sv */
// Host-bus cycle handling: snoops for downstream DRAM traffic, writeback,
// interrupt acknowledge routing, lock policy, branch trace and special cycles.
// Assumes one clock domain, host and hub interface logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "hbs_map.svh"

module hbs_host_cycles
  import hbs_pkg::*;
(
  input  wire logic                   clk,            // Host clock, 25 MHz.
  input  wire logic                   reset,          // Synchronous reset, active high.
  input  wire hbs_pkg::hbs_host_req_t host_req,       // Decoded host request, one-cycle pulse.
  input  wire logic                   modified_hit_snoop, // Modified-hit sampled in snoop phase.
  input  wire logic                   host_lock_done, // Host lock sequence finished, pulse.
  input  wire hbs_pkg::hbs_dn_req_t   dn_req,         // Downstream DRAM request, held until granted.
  output logic                        dn_grant,       // Downstream request accepted, combinational.
  output logic                        snoop_valid,    // Zero-length snoop cycle on the host bus.
  output logic                        snoop_invalidate, // Snoop is a read-invalidate.
  input  wire logic                   snoop_ready,    // Host bus took the snoop cycle.
  output logic [2:0]                  resp_code,      // Host response code.
  output logic                        resp_valid,     // Host response strobe, one cycle.
  output logic [1:0]                  write_xfers,    // Data transfers to accept for the write.
  output logic                        master_abort,   // Master abort to the host.
  output hbs_pkg::hbs_fwd_t           fwd_kind,       // Special cycle for hub interface A.
  output logic                        fwd_valid,      // Special cycle request to hub interface A.
  input  wire logic                   fwd_done,       // Hub interface A broadcast succeeded.
  output logic                        intack_to_hub_a, // Interrupt acknowledge routed to hub A.
  output logic                        host_busy,      // Block cannot take a new host request.
  output logic                        mgmt_mode,      // Management mode active.
  output logic                        mgmt_space_sel  // Current access goes to management space.
);
  import hbs_pkg::*;

  // ==========================================================================
  // Decode
  // ==========================================================================

  // True when the request phases describe a special cycle.
  function automatic logic is_special(input hbs_host_req_t r);
    is_special = (r.request_field_first == `HBS_REQ_FIRST_SPECIAL) &&
                 (r.request_field_second[2:0] == `HBS_REQ_SECOND_SPECIAL);
  endfunction

  // Number of snoop lines a downstream read needs.
  // Worked in 13 bits so that the longest burst still counts its full 128 lines.
  function automatic logic [7:0] snoop_count(input hbs_dn_req_t d);
    logic [12:0] n;
    n = ({1'b0, d.length} + {1'b0, `HBS_LINE_BYTES} - 13'h0001) >> `HBS_LINE_SHIFT;
    if (!d.is_burst || d.is_write || n == 13'h0000)
      snoop_count = 8'h01;
    else
      snoop_count = n[7:0];
  endfunction

  logic special_hit;
  logic btrace_hit;
  logic intack_hit;
  logic [7:0] sc_code;
  assign special_hit = host_req.valid && is_special(host_req);
  assign btrace_hit  = host_req.valid && host_req.request_field_first == `HBS_REQ_FIRST_SPECIAL &&
                       host_req.request_field_second[2:0] == `HBS_REQ_SECOND_BTRACE;
  assign intack_hit  = host_req.valid && host_req.request_field_first == `HBS_REQ_FIRST_INTACK &&
                       host_req.request_field_second[2:0] == `HBS_REQ_SECOND_INTACK;
  assign sc_code     = host_req.byte_enable_lines;

  // ==========================================================================
  // Special cycle and lock sequencer
  // ==========================================================================

  typedef enum logic [1:0] {HS_IDLE, HS_FWD, HS_LOCKED, HS_UNLOCK} hbs_hstate_t;
  hbs_hstate_t hs_q;
  logic        locked_q;
  logic        pend_retire_q;
  logic        lock_dram_q;
  logic        lock_hub_hit;

  // A locked access to the hub side is retired only after its LOCK cycle went out.
  assign lock_hub_hit = (hs_q == HS_IDLE) && host_req.valid && host_req.is_lock && !host_req.to_dram;

  // Sequencer: forwards special cycles and brackets host locks to hub A.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hs_q          <= HS_IDLE;
      fwd_kind      <= HBS_FWD_NONE;
      locked_q      <= 1'b0;
      pend_retire_q <= 1'b0;
    end
    else
    begin
      unique case (hs_q)
        HS_IDLE:
        begin
          if (special_hit && (sc_code == `HBS_SC_SHUTDOWN || sc_code == `HBS_SC_HALT ||
                              sc_code == `HBS_SC_STOPACK))
          begin
            hs_q          <= HS_FWD;
            pend_retire_q <= 1'b1;
            fwd_kind      <= (sc_code == `HBS_SC_SHUTDOWN) ? HBS_FWD_SHUTDOWN :
                             (sc_code == `HBS_SC_HALT) ? HBS_FWD_HALT : HBS_FWD_STOPACK;
          end
          else if (host_req.valid && host_req.is_lock && !host_req.to_dram)
          begin
            hs_q          <= HS_FWD;
            pend_retire_q <= 1'b1;
            fwd_kind      <= HBS_FWD_LOCK;
            locked_q      <= 1'b1;
          end
          else if (host_req.valid && host_req.is_lock)
          begin
            hs_q     <= HS_LOCKED;
            locked_q <= 1'b1;
          end
        end
        HS_FWD:
        begin
          if (fwd_done)
          begin
            fwd_kind <= HBS_FWD_NONE;
            pend_retire_q <= 1'b0;
            if (fwd_kind == HBS_FWD_LOCK)
              hs_q <= HS_LOCKED;
            else if (fwd_kind == HBS_FWD_UNLOCK)
            begin
              hs_q     <= HS_IDLE;
              locked_q <= 1'b0;
            end
            else
              hs_q <= HS_IDLE;
          end
        end
        HS_LOCKED:
        begin
          if (host_lock_done && fwd_kind == HBS_FWD_NONE && locked_q)
          begin
            hs_q     <= HS_UNLOCK;
          end
        end
        HS_UNLOCK:
        begin
          hs_q     <= HS_FWD;
          fwd_kind <= HBS_FWD_UNLOCK;
        end
      endcase
      // A DRAM lock needs no hub bracket: release straight away.
      if (hs_q == HS_LOCKED && host_lock_done && lock_dram_q)
      begin
        hs_q     <= HS_IDLE;
        locked_q <= 1'b0;
      end
    end
  end

  // Remembers whether the current lock targets DRAM.
  always_ff @(posedge clk)
  begin
    if (reset)
      lock_dram_q <= 1'b0;
    else if (hs_q == HS_IDLE && host_req.valid && host_req.is_lock)
      lock_dram_q <= host_req.to_dram;
  end

  assign fwd_valid = (hs_q == HS_FWD);
  assign host_busy = (hs_q == HS_FWD) || (hs_q == HS_UNLOCK);

  // ==========================================================================
  // Management mode
  // ==========================================================================

  // Enters or leaves management mode on the acknowledge code; never forwarded.
  always_ff @(posedge clk)
  begin
    if (reset)
      mgmt_mode <= 1'b0;
    else if (special_hit && sc_code == `HBS_SC_SMIACK)
      mgmt_mode <= host_req.address_phase_second_mgmt_bit;
  end

  // Later host accesses with the bit set go to management space.
  always_ff @(posedge clk)
  begin
    if (reset)
      mgmt_space_sel <= 1'b0;
    else
      mgmt_space_sel <= host_req.valid && !special_hit && mgmt_mode &&
                        host_req.address_phase_second_mgmt_bit;
  end

  // ==========================================================================
  // Host responses
  // ==========================================================================

  // Answers each host cycle but a shutdown, halt or stop-ack special in HS_LOCKED; forwarded specials answer after broadcast.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      resp_valid      <= 1'b0;
      resp_code       <= `HBS_RS_NODATA;
      write_xfers     <= 2'h0;
      intack_to_hub_a <= 1'b0;
      master_abort    <= 1'b0;
    end
    else
    begin
      resp_valid      <= 1'b0;
      intack_to_hub_a <= intack_hit;
      master_abort    <= 1'b0;
      if (hs_q == HS_FWD && fwd_done && pend_retire_q)
      begin
        resp_valid <= 1'b1;
        resp_code  <= (fwd_kind == HBS_FWD_LOCK) ? `HBS_RS_NORMAL : `HBS_RS_NODATA;
      end
      else if (special_hit && !(sc_code == `HBS_SC_SHUTDOWN || sc_code == `HBS_SC_HALT ||
                                sc_code == `HBS_SC_STOPACK))
      begin
        resp_valid <= 1'b1;
        resp_code  <= `HBS_RS_NODATA;
      end
      else if (btrace_hit)
      begin
        resp_valid <= 1'b1;
        resp_code  <= `HBS_RS_NODATA;
      end
      // The acknowledge returns its vector as read data, so the host gets a data response.
      else if (intack_hit)
      begin
        resp_valid  <= 1'b1;
        resp_code   <= `HBS_RS_NORMAL;
        write_xfers <= 2'h0;
      end
      else if (host_req.valid && !special_hit && !intack_hit && !lock_hub_hit && modified_hit_snoop)
      begin
        resp_valid  <= 1'b1;
        resp_code   <= `HBS_RS_IWB;
        write_xfers <= host_req.is_write ? 2'h2 : 2'h1;
      end
      else if (host_req.valid && !special_hit && !intack_hit && !lock_hub_hit)
      begin
        resp_valid  <= 1'b1;
        resp_code   <= host_req.is_write ? `HBS_RS_NODATA : `HBS_RS_NORMAL;
        write_xfers <= host_req.is_write ? 2'h1 : 2'h0;
      end
    end
  end

  // ==========================================================================
  // Snoop generator for downstream DRAM traffic
  // ==========================================================================

  logic [7:0] snoop_left_q;
  logic       snoop_inv_q;
  assign dn_grant = dn_req.valid && snoop_left_q == 8'h00 && !locked_q;

  // Issues one or several zero-length snoops per downstream DRAM access.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      snoop_left_q <= 8'h00;
      snoop_inv_q  <= 1'b0;
    end
    else if (dn_grant)
    begin
      snoop_left_q <= snoop_count(dn_req);
      snoop_inv_q  <= dn_req.is_write;
    end
    else if (snoop_valid && snoop_ready)
      snoop_left_q <= snoop_left_q - 8'h01;
  end

  assign snoop_valid      = snoop_left_q != 8'h00;
  assign snoop_invalidate = snoop_inv_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================

  a_lock_blocks_grant: assert property (@(posedge clk) disable iff (reset)
    locked_q |-> !dn_grant) else $error("Downstream grant during host lock.");

  a_lock_no_snoop: assert property (@(posedge clk) disable iff (reset)
    locked_q |=> snoop_left_q <= $past(snoop_left_q)) else $error("New snoops started during host lock.");

  a_short_one_snoop: assert property (@(posedge clk) disable iff (reset)
    (dn_grant && !dn_req.is_burst) |=> snoop_left_q == 8'h01)
    else $error("Short read did not yield one snoop.");

  a_iwb_response: assert property (@(posedge clk) disable iff (reset)
    (host_req.valid && modified_hit_snoop && !special_hit && !intack_hit && hs_q == HS_IDLE &&
     !btrace_hit && !lock_hub_hit && !(hs_q == HS_FWD && fwd_done)) |=> resp_valid && resp_code == `HBS_RS_IWB)
    else $error("Modified hit did not give writeback response.");

  a_write_two_xfers: assert property (@(posedge clk) disable iff (reset)
    (resp_valid && resp_code == `HBS_RS_IWB && $past(host_req.is_write)) |-> write_xfers == 2'h2)
    else $error("Writeback write lacks two transfers.");

  a_intack_route: assert property (@(posedge clk) disable iff (reset)
    intack_hit |=> intack_to_hub_a) else $error("Interrupt acknowledge not routed.");

  a_no_abort: assert property (@(posedge clk) disable iff (reset)
    !master_abort) else $error("Master abort asserted.");

  a_smm_enter: assert property (@(posedge clk) disable iff (reset)
    (special_hit && sc_code == `HBS_SC_SMIACK && host_req.address_phase_second_mgmt_bit)
    |=> mgmt_mode && !fwd_valid) else $error("Management mode entry wrong.");

  a_smm_exit: assert property (@(posedge clk) disable iff (reset)
    (special_hit && sc_code == `HBS_SC_SMIACK && !host_req.address_phase_second_mgmt_bit)
    |=> !mgmt_mode) else $error("Management mode exit wrong.");

  a_flush_local: assert property (@(posedge clk) disable iff (reset)
    (special_hit && hs_q == HS_IDLE && (sc_code == `HBS_SC_FLUSH || sc_code == `HBS_SC_SYNC))
    |=> resp_valid && hs_q == HS_IDLE) else $error("Flush or sync not retired locally.");

  a_fwd_retire: assert property (@(posedge clk) disable iff (reset)
    (hs_q == HS_FWD && pend_retire_q && !fwd_done) |=> !(resp_valid && resp_code == `HBS_RS_NODATA
     && $past(pend_retire_q) && !$past(special_hit) && !$past(btrace_hit) && !$past(host_req.valid)))
    else $error("Forwarded special retired before broadcast.");

endmodule // hbs_host_cycles
`default_nettype wire

/* File: hdl/hbs_map.svh */
// Constants for the host-bus snoop, lock and special-cycle block.
// Assumes it is included by the package and the design file by bare name.
`ifndef HBS_MAP_SVH
`define HBS_MAP_SVH
// Request field encodings for a special, branch trace or interrupt acknowledge cycle.
`define HBS_REQ_FIRST_SPECIAL  5'h08
`define HBS_REQ_SECOND_SPECIAL 3'h1
`define HBS_REQ_SECOND_BTRACE  3'h2
`define HBS_REQ_FIRST_INTACK   5'h08
`define HBS_REQ_SECOND_INTACK  3'h0
// Special cycle codes on the byte-enable lines.
`define HBS_SC_NOP      8'h00
`define HBS_SC_SHUTDOWN 8'h01
`define HBS_SC_FLUSH    8'h02
`define HBS_SC_HALT     8'h03
`define HBS_SC_SYNC     8'h04
`define HBS_SC_FLUSHACK 8'h05
`define HBS_SC_STOPACK  8'h06
`define HBS_SC_SMIACK   8'h07
// Snoop line size in bytes and its log2, the shift from bytes to lines.
`define HBS_LINE_BYTES  12'h020
`define HBS_LINE_SHIFT  5
// Host response codes.
`define HBS_RS_NODATA   3'h5
`define HBS_RS_IWB      3'h6
`define HBS_RS_NORMAL   3'h7
`endif

/* File: hdl/hbs_pkg.sv */
// Types for the host-bus snoop, lock and special-cycle block.
// Assumes hbs_map.svh is reachable on the include path.
`include "hbs_map.svh"
package hbs_pkg;
  // Host request as decoded from the two request phases.
  typedef struct packed {
    logic        valid;
    logic [4:0]  request_field_first;
    logic [4:0]  request_field_second;
    logic [7:0]  byte_enable_lines;
    logic        address_phase_second_mgmt_bit;
    logic        is_lock;
    logic        is_write;
    logic        to_dram;
  } hbs_host_req_t;
  // Downstream (hub or graphics) DRAM request needing a snoop.
  typedef struct packed {
    logic        valid;
    logic        is_write;
    logic        is_burst;
    logic [11:0] length;
  } hbs_dn_req_t;
  // Kind of special cycle sent over hub interface A.
  typedef enum logic [2:0] {
    HBS_FWD_NONE, HBS_FWD_SHUTDOWN, HBS_FWD_HALT, HBS_FWD_STOPACK,
    HBS_FWD_LOCK, HBS_FWD_UNLOCK
  } hbs_fwd_t;
endpackage

/* File: testbench/hbs_far_model.sv */
// Far-side model: host bus agents taking snoops, hub interface A taking specials.
// Assumes it runs on the block clock and the bench sets the answer latency.
`timescale 1ns/10ps
`default_nettype none
module hbs_far_model
  import hbs_pkg::*;
(
  input  wire logic              clk,         // Block clock.
  input  wire logic              snoop_valid, // Snoop pending from the block.
  input  wire logic              fwd_valid,   // Special cycle pending.
  input  wire hbs_pkg::hbs_fwd_t fwd_kind,    // Kind of that special cycle.
  input  wire logic [3:0]        lat,         // Idle cycles before each answer.
  output logic                   snoop_ready, // Snoop taken by the host bus.
  output logic                   fwd_done,    // Broadcast finished on hub A.
  output int                     snoops,      // Snoops taken so far.
  output int                     fwds,        // Special cycles taken so far.
  output hbs_pkg::hbs_fwd_t      last_fwd     // Kind of the last one taken.
);
  logic [3:0] wait_q;
  // Starts idle at time zero, then answers one request at a time after lat idle cycles.
  // Snoops go first; one process owns every output so nothing has two drivers.
  initial
  begin
    snoop_ready = 1'b0;
    fwd_done = 1'b0;
    snoops = 0;
    fwds = 0;
    last_fwd = HBS_FWD_NONE;
    wait_q = 4'h0;
    forever
    begin
      @(negedge clk);
      if (snoop_ready || fwd_done || !(snoop_valid || fwd_valid))
      begin
        snoop_ready = 1'b0;
        fwd_done = 1'b0;
        wait_q = 4'h0;
      end
      else if (wait_q < lat)
        wait_q = wait_q + 4'h1;
      else if (snoop_valid)
      begin
        snoop_ready = 1'b1;
        snoops = snoops + 1;
      end
      else
      begin
        fwd_done = 1'b1;
        fwds = fwds + 1;
        last_fwd = fwd_kind;
      end
    end
  end
endmodule // hbs_far_model
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the host-bus cycle block with its far-side model.
// Assumes the package and design are compiled first and hbs_map.svh is on the path.
`timescale 1ns/10ps
`default_nettype none
`include "hbs_map.svh"
// Compares an expectation with what was seen and counts the outcome.
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module testbench;
  import hbs_pkg::*;
  typedef struct packed { logic [7:0] code; hbs_fwd_t kind; } hbs_row_t;
  hbs_host_req_t hreq;
  hbs_dn_req_t   dreq;
  hbs_fwd_t      fwd_kind, last_fwd;
  logic [2:0]    resp_code;
  logic [1:0]    wxf;
  logic [3:0]    lat;
  logic          clk, reset, mhit, lock_done, dn_grant, snoop_valid, snoop_inv, snoop_ready;
  logic          resp_valid, mabort, fwd_valid, fwd_done, intack, busy, mmode, msel;
  int            snoops, fwds, failures, checked, resps, intacks, sels, f0, i0, k;
  hbs_row_t      rows [9] = '{'{`HBS_SC_NOP, HBS_FWD_NONE}, '{`HBS_SC_SHUTDOWN, HBS_FWD_SHUTDOWN},
    '{`HBS_SC_FLUSH, HBS_FWD_NONE}, '{`HBS_SC_HALT, HBS_FWD_HALT}, '{`HBS_SC_SYNC, HBS_FWD_NONE},
    '{`HBS_SC_FLUSHACK, HBS_FWD_NONE}, '{`HBS_SC_STOPACK, HBS_FWD_STOPACK}, '{8'h08, HBS_FWD_NONE},
    '{8'hFF, HBS_FWD_NONE}};

  hbs_host_cycles uut (.clk(clk), .reset(reset), .host_req(hreq), .modified_hit_snoop(mhit),
    .host_lock_done(lock_done), .dn_req(dreq), .dn_grant(dn_grant), .snoop_valid(snoop_valid),
    .snoop_invalidate(snoop_inv), .snoop_ready(snoop_ready), .resp_code(resp_code),
    .resp_valid(resp_valid), .write_xfers(wxf), .master_abort(mabort), .fwd_kind(fwd_kind),
    .fwd_valid(fwd_valid), .fwd_done(fwd_done), .intack_to_hub_a(intack), .host_busy(busy),
    .mgmt_mode(mmode), .mgmt_space_sel(msel));
  hbs_far_model far (.clk(clk), .snoop_valid(snoop_valid), .fwd_valid(fwd_valid), .fwd_kind(fwd_kind),
    .lat(lat), .snoop_ready(snoop_ready), .fwd_done(fwd_done), .snoops(snoops), .fwds(fwds),
    .last_fwd(last_fwd));

  // ==========================================================================
  // Clock, pulse counters and run control
  // Clock of 40 ns period.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Counts the one-cycle pulses of the block so that no pulse is missed.
  always @(posedge clk)
  begin
    resps += (resp_valid === 1'b1);
    intacks += (intack === 1'b1);
    sels += (msel === 1'b1);
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Cuts a hang short well past the expected run of under 1500 cycles.
  initial
  begin
    #(6000 * 40);
    failures++;
    test_done();
  end

  // ==========================================================================
  // Drivers
  // Sends one host request for one cycle when free and waits for its response.
  task automatic op(input logic [4:0] f, s, input logic [7:0] be, input logic [3:0] fl, input logic hit);
    int r0;
    r0 = resps;
    for (k = 0; busy !== 1'b0 && k < 50; k++) @(negedge clk);
    hreq = {1'b1, f, s, be, fl};
    mhit = hit;
    @(negedge clk);
    hreq = '0;
    mhit = 1'b0;
    for (k = 0; resps == r0 && k < 60; k++) @(negedge clk);
    `CHK("response", 1'b1, resps == r0 + 1)
  endtask
  // Holds a downstream request until granted, then counts the snoops it causes.
  task automatic dn(input logic wr, burst, input logic [11:0] len, input int exp);
    int s0, r0;
    s0 = snoops;
    r0 = resps;
    dreq = {1'b1, wr, burst, len};
    #1;
    for (k = 0; dn_grant !== 1'b1 && k < 60; k++) @(negedge clk) #1;
    @(negedge clk);
    dreq = '0;
    `CHK("invalidate", wr, snoop_inv)
    for (k = 0; (snoop_valid !== 1'b0 || k < 2) && k < 200; k++) @(negedge clk);
    `CHK("snoops", exp, snoops - s0)
    `CHK("snoop data", r0, resps)
    $display("test snoop of %0d bytes finished", len);
  endtask

  // ==========================================================================
  // Main sequence
  // Downstream requests never carry a lock.
  initial
  begin
    {hreq, dreq, mhit, lock_done, resps, intacks, sels, failures, checked} = '0;
    lat = 4'h3;
    reset = 1'b1;
    repeat (5) @(negedge clk);
    `CHK("reset resp", 3'h5, resp_code)
    reset = 1'b0;
    `CHK("reset idle", 4'h0, {snoop_valid, fwd_valid, mmode, busy})
    // Every special code but the management acknowledge: forwarded kinds wait for hub A, the rest retire locally.
    foreach (rows[i])
    begin
      f0 = fwds;
      op(`HBS_REQ_FIRST_SPECIAL, {2'b00, `HBS_REQ_SECOND_SPECIAL}, rows[i].code, 4'h0, 1'b0);
      `CHK("fwd count", rows[i].kind != HBS_FWD_NONE, fwds == f0 + 1)
      if (rows[i].kind != HBS_FWD_NONE) `CHK("fwd kind", rows[i].kind, last_fwd)
      `CHK("special resp", 3'h5, resp_code)
      `CHK("special mgmt", 1'b0, mmode)
    end
    $display("test special table finished");
    lat = 4'h0;
    dn(1'b0, 1'b1, 12'h060, 3);
    dn(1'b0, 1'b1, 12'h021, 2);
    dn(1'b0, 1'b1, 12'h020, 1);
    dn(1'b0, 1'b0, 12'h008, 1);
    lat = 4'h2;
    dn(1'b1, 1'b0, 12'h020, 1);
    // Modified hits on a read and a write, then a clean read.
    op(5'h06, 5'h00, 8'hFF, 4'h1, 1'b1);
    `CHK("read hit resp", 3'h6, resp_code)
    op(5'h07, 5'h00, 8'hFF, 4'h3, 1'b1);
    `CHK("write hit resp", 3'h6, resp_code)
    `CHK("write xfers", 2'h2, wxf)
    op(5'h06, 5'h00, 8'hFF, 4'h1, 1'b0);
    `CHK("clean read resp", 3'h7, resp_code)
    // Interrupt acknowledge goes to hub A; branch trace retires with nothing forwarded.
    {f0, i0} = {fwds, intacks};
    op(`HBS_REQ_FIRST_INTACK, {2'b00, `HBS_REQ_SECOND_INTACK}, 8'h00, 4'h0, 1'b0);
    `CHK("intack", i0 + 1, intacks)
    op(`HBS_REQ_FIRST_SPECIAL, {2'b00, `HBS_REQ_SECOND_BTRACE}, 8'hFF, 4'h0, 1'b0);
    `CHK("btrace fwd", f0, fwds)
    `CHK("btrace abort", 1'b0, mabort)
    $display("test coherency and routing finished");
    // Management acknowledge enters the mode, a marked access selects the space, a second one leaves.
    op(`HBS_REQ_FIRST_SPECIAL, {2'b00, `HBS_REQ_SECOND_SPECIAL}, `HBS_SC_SMIACK, 4'h8, 1'b0);
    `CHK("mgmt enter", 1'b1, mmode)
    `CHK("mgmt no fwd", f0, fwds)
    i0 = sels;
    op(5'h06, 5'h00, 8'hFF, 4'h9, 1'b0);
    `CHK("mgmt space", i0 + 1, sels)
    op(`HBS_REQ_FIRST_SPECIAL, {2'b00, `HBS_REQ_SECOND_SPECIAL}, `HBS_SC_SMIACK, 4'h0, 1'b0);
    `CHK("mgmt exit", 1'b0, mmode)
    $display("test management mode finished");
    // Locked reads to the hub side then to DRAM; locks never aim at graphics.
    for (int d = 0; d < 2; d++)
    begin
      lat = 4'h1;
      f0 = fwds;
      op(5'h06, 5'h00, 8'hFF, {3'b010, d[0]}, 1'b0);
      `CHK("lock fwd", d == 0, fwds == f0 + 1)
      if (d == 0) `CHK("lock kind", HBS_FWD_LOCK, last_fwd)
      `CHK("lock abort", 1'b0, mabort)
      dreq = {1'b1, 1'b0, 1'b0, 12'h020};
      repeat (4) @(negedge clk) `CHK("lock hold", 1'b0, dn_grant)
      lock_done = 1'b1;
      @(negedge clk);
      lock_done = 1'b0;
      for (k = 0; d == 0 && fwds == f0 + 1 && k < 40; k++) @(negedge clk);
      if (d == 0) `CHK("unlock kind", HBS_FWD_UNLOCK, last_fwd)
      dn(1'b0, 1'b0, 12'h020, 1);
    end
    $display("test locks finished");
    // A reset in mid-run drops management mode; the first request after it is served.
    op(`HBS_REQ_FIRST_SPECIAL, {2'b00, `HBS_REQ_SECOND_SPECIAL}, `HBS_SC_SMIACK, 4'h8, 1'b0);
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    `CHK("mid reset mgmt", 1'b0, mmode)
    `CHK("mid reset idle", 3'h0, {snoop_valid, fwd_valid, busy})
    `CHK("mid reset resp", 3'h5, resp_code)
    op(5'h06, 5'h00, 8'hFF, 4'h1, 1'b0);
    `CHK("after reset resp", 3'h7, resp_code)
    $display("test reset finished");
    test_done();
  end
endmodule // testbench
`default_nettype wire
